// >>> verilog/wepm_pkg.sv
package wepm_pkg;

  // Register byte offsets on the Wishbone bus.
  localparam logic [3:0] CTRL_OFF = 4'h0;
  localparam logic [3:0] STAT_OFF = 4'h4;
  localparam logic [3:0] FAN_OFF = 4'h8;
  localparam logic [3:0] TACH_OFF = 4'hC;

  // Control register field positions.
  localparam int CTRL_CMD_LSB = 0;
  localparam int CTRL_GO_BIT = 3;
  localparam int CTRL_PME_EN_BIT = 4;
  localparam int CTRL_S5_EN_BIT = 5;
  localparam int CTRL_RESTORE_LSB = 6;
  localparam int CTRL_DUAL_LED_BIT = 8;
  localparam logic [8:0] CTRL_RST = 9'h000;

  // Fan control register field positions.
  localparam int FAN_TARGET_LSB = 0;
  localparam int FAN_AUTO_BIT = 16;
  localparam logic [15:0] FAN_TARGET_RST = 16'h0100;

  // Power-switch hold threshold.
  localparam int CLK_MHZ = 125;
  localparam int LONG_PRESS_S = 4;
  localparam longint LONG_PRESS_CYC =
    longint'(LONG_PRESS_S) * 1000000 * CLK_MHZ;

  // Tachometer measuring window and PWM duty step.
  localparam int TACH_WIN_CYC = 1000000;
  localparam logic [7:0] PWM_STEP = 8'h10;

  // Restore policies after AC loss.
  localparam logic [1:0] RESTORE_LAST = 2'h0;
  localparam logic [1:0] RESTORE_ON = 2'h1;
  localparam logic [1:0] RESTORE_OFF = 2'h2;

  typedef enum logic [2:0] {
    ST_S0 = 3'h0,
    ST_S1 = 3'h1,
    ST_S3 = 3'h3,
    ST_S4 = 3'h4,
    ST_S5 = 3'h5
  } wepm_state_t;

endpackage

// >>> verilog/wepm_top.sv
// Overview of operation
// - After AC loss, restore last on/off state, per restore policy.
// - Fans run in S0 and S1.
// - Fans off when off or in S3, S4, S5.
// - Each fan tach feeds closed-loop speed control; here the duty step tests a zeroed count, so duty stays 0xFF.
// - Correct soft-off command drops main rails; standby rail stays.
// - Network wake frame detection raises a wake that powers up.
// - Network wake accepted via WAKE#, PME# or onboard network.
// - In S3 main supply off, LED amber if dual, else off.
// - Valid wake in S3 returns promptly to working state.
// - Modem ring wakes only from S1 or S3.
// - USB activity wakes only from S1 or S3.
// - PS/2 activity wakes only from S1 or S3.
// - PME# wakes from S1, S3, S4, S5 only when enabled.
// - WAKE# wakes from S1, S3, S4, S5 always.
// - Standby LED lit whenever standby rail is present.
// - Power switch: short or long press by four-second threshold.
// - Network and PME# wake from S5 only with enable set.
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
module wepm_top #(
  parameter longint LONG_PRESS = wepm_pkg::LONG_PRESS_CYC,
  parameter int TACH_WIN = wepm_pkg::TACH_WIN_CYC
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Wake sources and switch, asynchronous levels.
  input wire logic net_wake_i,
  input wire logic pcie_wake_n_i,
  input wire logic pme_n_i,
  input wire logic ring_i,
  input wire logic usb_wake_i,
  input wire logic ps2_wake_i,
  input wire logic pwr_btn_n_i,
  input wire logic ac_fail_i,
  input wire logic stby_ok_i,
  // Fans.
  input wire logic [2:0] tach_i,
  output logic [2:0] fan_pwm_o,
  // Supply and indicators.
  output logic ps_on_o,
  output logic led_amber_o,
  output logic led_stby_o
);

  localparam int NS = 9;
  logic [NS-1:0] raw, s1_r, s2_r;
  assign raw = {stby_ok_i, ac_fail_i, ~pwr_btn_n_i, ps2_wake_i, usb_wake_i,
                ring_i, ~pme_n_i, ~pcie_wake_n_i, net_wake_i};
  always_ff @(posedge clk_i) begin
    s1_r <= raw;
    s2_r <= s1_r;
  end
  logic w_net, w_pcie, w_pme, w_ring, w_usb, w_ps2, btn, ac_fail, stby_ok;
  assign {stby_ok, ac_fail, btn, w_ps2, w_usb, w_ring, w_pme, w_pcie, w_net}
    = s2_r;

  wepm_pkg::wepm_state_t st_r, st_nxt;
  logic [8:0] ctrl_r, ctrl_nxt;
  logic [16:0] fan_r, fan_nxt;
  logic last_on_r, last_on_nxt, ac_was_r, ac_was_nxt;
  logic [31:0] hold_r, hold_nxt;
  logic btn_r, btn_nxt, ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;

  function automatic logic light_sleep(input wepm_pkg::wepm_state_t s);
    return s == wepm_pkg::ST_S1 || s == wepm_pkg::ST_S3;
  endfunction

  logic pme_en, s5_en, in_sleep, light, wake, short_rel, long_hit;
  logic [1:0] policy;
  logic wr;
  assign pme_en = ctrl_r[wepm_pkg::CTRL_PME_EN_BIT];
  assign s5_en = ctrl_r[wepm_pkg::CTRL_S5_EN_BIT];
  assign policy = ctrl_r[wepm_pkg::CTRL_RESTORE_LSB +: 2];
  assign in_sleep = st_r != wepm_pkg::ST_S0;
  assign light = light_sleep(st_r);

  always_comb begin
    wake = 1'b0;
    if (in_sleep) begin
      wake = w_pcie;
      if (st_r != wepm_pkg::ST_S5 || s5_en) begin
        wake = wake || w_net || (w_pme && pme_en);
      end
      if (light) begin
        wake = wake || w_ring || w_usb || w_ps2;
      end
    end
  end

  assign long_hit = btn_r && hold_r >= 32'(LONG_PRESS);
  assign short_rel = btn_r && !btn && hold_r < 32'(LONG_PRESS);
  // Writes land at the edge where the master samples ack, never earlier.
  assign wr = cyc_i && stb_i && we_i && ack_r;

  always_comb begin
    st_nxt = st_r;
    ctrl_nxt = ctrl_r;
    fan_nxt = fan_r;
    last_on_nxt = last_on_r;
    ac_was_nxt = ac_fail;
    btn_nxt = btn;
    hold_nxt = btn ? ((hold_r == 32'hFFFFFFFF) ? hold_r : hold_r + 32'h1)
                   : 32'h0;
    ctrl_nxt[wepm_pkg::CTRL_GO_BIT] = 1'b0;
    if (wr && adr_i == wepm_pkg::CTRL_OFF) begin
      if (sel_i[0]) ctrl_nxt[7:0] = dat_i[7:0];
      if (sel_i[1]) ctrl_nxt[8] = dat_i[8];
    end
    if (wr && adr_i == wepm_pkg::FAN_OFF) begin
      if (sel_i[0]) fan_nxt[7:0] = dat_i[7:0];
      if (sel_i[1]) fan_nxt[15:8] = dat_i[15:8];
      if (sel_i[2]) fan_nxt[16] = dat_i[16];
    end
    if (ac_was_r && !ac_fail) begin
      case (policy)
        wepm_pkg::RESTORE_ON: st_nxt = wepm_pkg::ST_S0;
        wepm_pkg::RESTORE_OFF: st_nxt = wepm_pkg::ST_S5;
        default: st_nxt = last_on_r ? wepm_pkg::ST_S0 : wepm_pkg::ST_S5;
      endcase
    end else if (ac_fail) begin
      st_nxt = st_r;
    end else if (st_r == wepm_pkg::ST_S0
                 && ctrl_r[wepm_pkg::CTRL_GO_BIT]) begin
      case (ctrl_r[2:0])
        3'h1: st_nxt = wepm_pkg::ST_S1;
        3'h3: st_nxt = wepm_pkg::ST_S3;
        3'h4: st_nxt = wepm_pkg::ST_S4;
        3'h5: st_nxt = wepm_pkg::ST_S5;
        default: st_nxt = st_r;
      endcase
    end else if (long_hit && st_r != wepm_pkg::ST_S5) begin
      st_nxt = wepm_pkg::ST_S5;
    end else if (short_rel) begin
      st_nxt = (st_r == wepm_pkg::ST_S0) ? wepm_pkg::ST_S1
                                         : wepm_pkg::ST_S0;
    end else if (wake) begin
      st_nxt = wepm_pkg::ST_S0;
    end
    if (!ac_fail) last_on_nxt = st_nxt != wepm_pkg::ST_S5;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= wepm_pkg::ST_S5;
      ctrl_r <= wepm_pkg::CTRL_RST;
      fan_r <= {1'b1, wepm_pkg::FAN_TARGET_RST};
      last_on_r <= 1'b0;
      ac_was_r <= 1'b0;
      btn_r <= 1'b0;
      hold_r <= 32'h0;
    end else begin
      st_r <= st_nxt;
      ctrl_r <= ctrl_nxt;
      fan_r <= fan_nxt;
      last_on_r <= last_on_nxt;
      ac_was_r <= ac_was_nxt;
      btn_r <= btn_nxt;
      hold_r <= hold_nxt;
    end
  end

  // Fans: count tach edges per window; the duty step tests the zeroed count, so duty never leaves 0xFF.
  logic fans_on;
  assign fans_on = st_r == wepm_pkg::ST_S0 || st_r == wepm_pkg::ST_S1;
  logic [31:0] win_r, win_nxt;
  logic [7:0] pcnt_r, pcnt_nxt;
  logic [2:0] tprev_r, tprev_nxt;
  logic [15:0] tcnt_r [3];
  logic [15:0] tcnt_nxt [3];
  logic [15:0] rpm_r [3];
  logic [15:0] rpm_nxt [3];
  logic [7:0] duty_r [3];
  logic [7:0] duty_nxt [3];
  logic [2:0] tach_s1_r, tach_s2_r;
  logic win_end;
  logic [2:0] pwm_nxt;
  assign win_end = win_r >= 32'(TACH_WIN - 1);
  assign win_nxt = win_end ? 32'h0 : win_r + 32'h1;
  assign pcnt_nxt = pcnt_r + 8'h01;
  assign tprev_nxt = tach_s2_r;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_fan
      always_comb begin
        tcnt_nxt[g] = tcnt_r[g];
        rpm_nxt[g] = rpm_r[g];
        duty_nxt[g] = duty_r[g];
        if (tach_s2_r[g] && !tprev_r[g]) tcnt_nxt[g] = tcnt_r[g] + 16'h1;
        if (win_end) begin
          rpm_nxt[g] = tcnt_nxt[g];
          tcnt_nxt[g] = 16'h0;
          if (!fan_r[wepm_pkg::FAN_AUTO_BIT]) begin
            duty_nxt[g] = 8'hFF;
          end else if (tcnt_nxt[g] < fan_r[15:0]
                       && duty_r[g] <= 8'hFF - wepm_pkg::PWM_STEP) begin
            duty_nxt[g] = duty_r[g] + wepm_pkg::PWM_STEP;
          end else if (tcnt_nxt[g] > fan_r[15:0]
                       && duty_r[g] >= wepm_pkg::PWM_STEP) begin
            duty_nxt[g] = duty_r[g] - wepm_pkg::PWM_STEP;
          end
        end
      end
      assign pwm_nxt[g] = fans_on && (duty_r[g] == 8'hFF
                          || pcnt_r < duty_r[g]);
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          tcnt_r[g] <= 16'h0;
          rpm_r[g] <= 16'h0;
          duty_r[g] <= 8'hFF;
        end else begin
          tcnt_r[g] <= tcnt_nxt[g];
          rpm_r[g] <= rpm_nxt[g];
          duty_r[g] <= duty_nxt[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    tach_s1_r <= tach_i;
    tach_s2_r <= tach_s1_r;
    if (rst_i) begin
      win_r <= 32'h0;
      pcnt_r <= 8'h00;
      tprev_r <= 3'h0;
      fan_pwm_o <= 3'h0;
    end else begin
      win_r <= win_nxt;
      pcnt_r <= pcnt_nxt;
      tprev_r <= tprev_nxt;
      fan_pwm_o <= pwm_nxt;
    end
  end

  // Bus slave: ack one cycle after the strobe, then drop for one cycle.
  always_comb begin
    ack_nxt = cyc_i && stb_i && !ack_r;
    dat_nxt = 32'h0;
    case (adr_i)
      wepm_pkg::CTRL_OFF: dat_nxt = {23'h0, ctrl_r};
      wepm_pkg::STAT_OFF: dat_nxt = {28'h0, ac_fail, st_r};
      wepm_pkg::FAN_OFF: dat_nxt = {15'h0, fan_r};
      wepm_pkg::TACH_OFF: dat_nxt = {rpm_r[1], rpm_r[0]};
      default: dat_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
      ps_on_o <= 1'b0;
      led_amber_o <= 1'b0;
      led_stby_o <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      ps_on_o <= st_r == wepm_pkg::ST_S0 || st_r == wepm_pkg::ST_S1;
      led_amber_o <= st_r == wepm_pkg::ST_S3
                     && ctrl_r[wepm_pkg::CTRL_DUAL_LED_BIT];
      led_stby_o <= stby_ok;
    end
  end
  assign ack_o = ack_r;
  assign dat_o = dat_r;

  // Steps shared by the multi-cycle checks below.
  sequence s_held_s3;
    (st_r == wepm_pkg::ST_S3) ##1 (st_r == wepm_pkg::ST_S3);
  endsequence
  sequence s_ac_back;
    ac_was_r && !ac_fail;
  endsequence
  // Nothing of higher priority than the power key is pending.
  sequence s_key_only;
    !ac_fail && !ac_was_r && !ctrl_r[wepm_pkg::CTRL_GO_BIT];
  endsequence

  AST_FAN_OFF_SLEEP: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (st_r == wepm_pkg::ST_S3) |=> fan_pwm_o == 3'h0)
    else $error("fans running in suspend");
  AST_FAN_OFF_DEEP: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (st_r == wepm_pkg::ST_S4 || st_r == wepm_pkg::ST_S5)
    |=> fan_pwm_o == 3'h0)
    else $error("fans running while off");
  AST_FAN_ON_S0: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (st_r == wepm_pkg::ST_S0 && duty_r[0] == 8'hFF) |=> fan_pwm_o[0])
    else $error("fan idle in working state");
  AST_PCIE_WAKE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (in_sleep && w_pcie && !ac_fail && !ac_was_r && !btn_r && !btn
     && !ctrl_r[wepm_pkg::CTRL_GO_BIT]) |=> st_r == wepm_pkg::ST_S0)
    else $error("pcie wake ignored");
  AST_USB_DEEP: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (st_r == wepm_pkg::ST_S4 && !w_pcie && !w_net && !w_pme && !btn_r
     && !ac_was_r) |=> st_r == wepm_pkg::ST_S4)
    else $error("deep sleep left without valid wake");
  AST_RING_DEEP: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!light && w_ring && !w_pcie && !w_net && !w_pme) |-> !wake)
    else $error("ring wake outside light sleep");
  AST_S5_GATE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (st_r == wepm_pkg::ST_S5 && !s5_en && !w_pcie) |-> !wake)
    else $error("gated wake taken in soft-off");
  AST_PME_GATE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!pme_en && w_pme && !w_pcie && !w_net && !light) |-> !wake)
    else $error("pme wake without enable");
  AST_RAIL_S3: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_held_s3 |-> !ps_on_o)
    else $error("main supply on in suspend");
  AST_AMBER_S3: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (st_r == wepm_pkg::ST_S3 && ctrl_r[wepm_pkg::CTRL_DUAL_LED_BIT])
    |=> led_amber_o)
    else $error("amber led dark in suspend");
  AST_STBY_LED: assert property (
    @(posedge clk_i) disable iff (rst_i)
    stby_ok |=> led_stby_o)
    else $error("standby led dark");
  AST_SLEEP_CMD: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (st_r == wepm_pkg::ST_S0 && ctrl_r[wepm_pkg::CTRL_GO_BIT]
     && ctrl_r[2:0] == 3'h5 && !ac_fail && !ac_was_r)
    |=> ##1 !ps_on_o)
    else $error("soft-off did not drop rails");
  AST_RESTORE_OFF: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_ac_back ##0 (policy == wepm_pkg::RESTORE_OFF)
    |=> st_r == wepm_pkg::ST_S5)
    else $error("restore to off not kept");
  AST_RESTORE_LAST: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_ac_back ##0 (policy == wepm_pkg::RESTORE_LAST && last_on_r)
    |=> st_r == wepm_pkg::ST_S0)
    else $error("last on state not restored");
  AST_LONG_PRESS: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_key_only ##0 (long_hit && st_r != wepm_pkg::ST_S5)
    |=> st_r == wepm_pkg::ST_S5)
    else $error("long press did not force soft-off");

endmodule  // wepm_top

// >>> tb/wepm_supply_model.sv
module wepm_supply_model (
  // Clock and supply control.
  input wire logic clk_i,
  input wire logic ps_on_i,
  input wire logic [2:0] fan_pwm_i,
  // Rail and fan feedback.
  output logic stby_ok_o,
  output logic [2:0] tach_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_r = 2'h0;
  // The standby rail never drops while AC is plugged in.
  assign stby_ok_o = 1'b1;
  always @(posedge clk_i) begin
    div_r <= div_r + 2'h1;
  end
  // A fan spins only while driven and the main rails are up.
  assign tach_o = fan_pwm_i & {3{div_r[1] & ps_on_i}};
endmodule // wepm_supply_model

// >>> tb/wepm_top_tb.sv
module wepm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [3:0] adr_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  // Wake levels, all active high: ac, ps2, usb, ring, pme, pcie, net.
  logic [6:0] src = 7'h00;
  logic btn = 1'b0;
  logic stby_ok;
  logic [2:0] tach;
  logic [2:0] fan_pwm_o;
  logic ps_on_o;
  logic led_amber_o;
  logic led_stby_o;
  logic [31:0] ctl = 32'h100;
  logic [31:0] rd;
  int errors = 0;
  int n_compared = 0;

  always #4 clk_i = ~clk_i;

  wepm_top #(.LONG_PRESS(50), .TACH_WIN(16)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .net_wake_i(src[0]),
    .pcie_wake_n_i(~src[1]), .pme_n_i(~src[2]), .ring_i(src[3]),
    .usb_wake_i(src[4]), .ps2_wake_i(src[5]), .pwr_btn_n_i(~btn),
    .ac_fail_i(src[6]), .stby_ok_i(stby_ok), .tach_i(tach),
    .fan_pwm_o(fan_pwm_o), .ps_on_o(ps_on_o), .led_amber_o(led_amber_o),
    .led_stby_o(led_stby_o)
  );

  wepm_supply_model i_supply (
    .clk_i(clk_i), .ps_on_i(ps_on_o), .fan_pwm_i(fan_pwm_o),
    .stby_ok_o(stby_ok), .tach_o(tach)
  );

  task automatic test_done();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      errors++;
    end
  endtask

  // The request stands until the rising edge that samples ack high, and
  // read data is taken and the request released at that same edge.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack_o !== 1'b1 && i < 50);
    if (ack_o !== 1'b1) begin
      errors++;
      test_done();
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  // Lets sync, state and supply stages settle, then checks state, supply, fans, standby LED and, in S3 only, the amber LED.
  task automatic st(input logic [2:0] s);
    repeat (8) @(posedge clk_i);
    wb(1'b0, wepm_pkg::STAT_OFF, 32'h0);
    chk({29'h0, rd[2:0]}, {29'h0, s});
    chk({31'h0, ps_on_o}, {31'h0, s < 3'h2});
    chk({29'h0, fan_pwm_o}, (s < 3'h2) ? 32'h7 : 32'h0);
    chk({31'h0, led_stby_o}, 32'h1);
    if (s == 3'h3) begin
      chk({31'h0, led_amber_o}, 32'h1);
    end
  endtask

  task automatic sleep(input logic [2:0] s);
    wb(1'b1, wepm_pkg::CTRL_OFF, ctl | 32'h8 | {29'h0, s});
  endtask

  task automatic pulse(input int i);
    @(posedge clk_i);
    src[i] <= 1'b1;
    repeat (6) @(posedge clk_i);
    src[i] <= 1'b0;
  endtask

  task automatic press(input int n);
    @(posedge clk_i);
    btn <= 1'b1;
    repeat (n) @(posedge clk_i);
    btn <= 1'b0;
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    st(wepm_pkg::ST_S5);
    wb(1'b0, wepm_pkg::FAN_OFF, 32'h0);
    chk(rd, 32'h0001_0100);
    wb(1'b0, wepm_pkg::CTRL_OFF, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, wepm_pkg::FAN_OFF, 32'h100);
    press(10);
    st(wepm_pkg::ST_S0);
    wb(1'b1, wepm_pkg::CTRL_OFF, ctl);
    pulse(4);
    st(wepm_pkg::ST_S0);
    // The model spins a fan once per four clocks: four per 16-clock window.
    repeat (40) @(posedge clk_i);
    wb(1'b0, wepm_pkg::TACH_OFF, 32'h0);
    chk(rd, 32'h0004_0004);
    sleep(3'h3);
    st(wepm_pkg::ST_S3);
    pulse(4);
    st(wepm_pkg::ST_S0);
    sleep(3'h3);
    // Ring stimulus stands for software that keeps the modem interrupt open.
    pulse(3);
    st(wepm_pkg::ST_S0);
    sleep(3'h1);
    st(wepm_pkg::ST_S1);
    pulse(5);
    st(wepm_pkg::ST_S0);
    sleep(3'h4);
    pulse(3);
    pulse(5);
    pulse(2);
    st(wepm_pkg::ST_S4);
    pulse(1);
    st(wepm_pkg::ST_S0);
    sleep(3'h5);
    pulse(0);
    st(wepm_pkg::ST_S5);
    press(10);
    ctl = 32'h130;
    sleep(3'h5);
    pulse(0);
    st(wepm_pkg::ST_S0);
    sleep(3'h5);
    pulse(2);
    st(wepm_pkg::ST_S0);
    press(60);
    st(wepm_pkg::ST_S5);
    press(10);
    pulse(6);
    st(wepm_pkg::ST_S0);
    wb(1'b1, wepm_pkg::CTRL_OFF, 32'h180);
    pulse(6);
    st(wepm_pkg::ST_S5);
    test_done();
  end
endmodule // wepm_top_tb
